// file: rtl/pcq_power_queue.sv
// Power control registers and sample queue of the motion sensor core.
`timescale 1ns/100ps
// Functional notes
// - Soft reset bit returns all registers but the count latch to defaults, then reads zero.
// - Sleep bit puts the chip asleep; it resets to one.
// - Cycle bit without sleep or standby alternates sleep and accel samples.
// - Cycling with every accel axis off wakes but captures nothing.
// - Gyro standby keeps drive and PLL running, turns sense paths off.
// - Thermal off bit turns the temperature sensor off.
// - Clock source field resets to zero; software should program one.
// - Sources: internal oscillator, PLL if ready else oscillator, stop.
// - Axis register bit 7 permits queue use in low-power accel mode.
// - Axis bits 5 to 3 switch accel X, Y, Z off when set.
// - Axis bits 2 to 0 switch gyro X, Y, Z off when set.
// - Queue byte count is 13 bits over high and low bytes.
// - Reading the high count byte latches the count; low byte reads return the latch, high byte reads stay live.
// - Data port read pops a byte, data port write pushes one.
// - Each sample tick pushes enabled sensor bytes in ascending order.
// - A sensor byte is pushed only if its enable flag was set at the sample tick.
// - Queue overflow raises the overflow status flag automatically.
// - Overflow drops oldest bytes unless stop-on-full mode drops new ones.
// - Reading an empty queue returns 0xFF until data arrives.
// - Sample bytes never enter the queue as 0xFF.
// - User control bit 6 enables queue; zero blocks host data access.
// - User control bit 2 resets the queue and clears after one cycle.
module pcq_power_queue
  import pcq_pkg::*;
#(
  parameter int QDEPTH = QDEPTH_DEF
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          linkClk,
  input  wire logic                          linkWrite,
  input  wire logic                          linkRead,
  input  wire logic [7:0]                    linkAddr,
  input  wire logic [7:0]                    linkWrData,
  output logic                               linkBusy,
  output logic                               linkRdValid,
  output logic [7:0]                         linkRdData,
  input  wire logic                          sampleTick,
  input  wire logic [SENSOR_BYTES-1:0][7:0]  sensorBytes,
  input  wire logic [4:0]                    queueSourceEn,
  input  wire logic                          queueStopOnFull,
  input  wire logic                          pllReady,
  output pcq_pwr_t                           powerState,
  output logic                               queue_overflow_flag
);

  localparam int PW = $clog2(QDEPTH);
  localparam int CW = $clog2(QDEPTH + 1);

  if (QDEPTH < 2 || QDEPTH >= (1 << LEVEL_W) ||
      (1 << PW) != QDEPTH) begin : g_depth_check
    $error("QDEPTH must be a power of two below 8192");
  end

  // ------------------------------------------------------------------
  // Resets in both domains.
  // ------------------------------------------------------------------
  logic [1:0] rstSys_ff;
  logic [1:0] rstLink_ff;
  logic       sysRst_n;
  logic       linkRst_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rstSys_ff <= 2'b00;
    else        rstSys_ff <= {rstSys_ff[0], 1'b1};
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) rstLink_ff <= 2'b00;
    else        rstLink_ff <= {rstLink_ff[0], 1'b1};
  end

  assign sysRst_n  = rstSys_ff[1];
  assign linkRst_n = rstLink_ff[1];

  // ------------------------------------------------------------------
  // Link side request capture and answer.
  // ------------------------------------------------------------------
  pcq_req_t   linkReq_ff;
  logic       reqTgl_ff;
  logic [1:0] ackSync_ff;
  logic [7:0] sysRdData_ff;
  logic       ackTgl_ff;

  always_ff @(posedge linkClk or negedge linkRst_n) begin
    if (!linkRst_n) ackSync_ff <= 2'b00;
    else            ackSync_ff <= {ackSync_ff[0], ackTgl_ff};
  end

  always_ff @(posedge linkClk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      linkReq_ff  <= '0;
      reqTgl_ff   <= 1'b0;
      linkBusy    <= 1'b0;
      linkRdValid <= 1'b0;
      linkRdData  <= 8'h00;
    end else begin
      linkRdValid <= 1'b0;
      if (linkBusy) begin
        if (ackSync_ff[1] == reqTgl_ff) begin
          linkBusy    <= 1'b0;
          linkRdValid <= !linkReq_ff.write;
          linkRdData  <= sysRdData_ff;
        end
      end else if (linkWrite || linkRead) begin
        linkReq_ff <= '{addr: linkAddr, data: linkWrData, write: linkWrite};
        reqTgl_ff  <= !reqTgl_ff;
        linkBusy   <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // System side request handling.
  // ------------------------------------------------------------------
  logic [1:0] reqSync_ff;
  logic [1:0] pllSync_ff;
  pcq_seq_t   seqState_ff;
  logic       softRst_ff;
  logic       reqPending;
  logic       serve;
  logic       hostWr;
  logic       hostRd;

  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      reqSync_ff <= 2'b00;
      pllSync_ff <= 2'b00;
    end else begin
      reqSync_ff <= {reqSync_ff[0], reqTgl_ff};
      pllSync_ff <= {pllSync_ff[0], pllReady};
    end
  end

  assign reqPending = reqSync_ff[1] != ackTgl_ff;
  assign serve      = reqPending && seqState_ff == SEQ_IDLE && !softRst_ff;
  assign hostWr     = serve && linkReq_ff.write;
  assign hostRd     = serve && !linkReq_ff.write;

  // ------------------------------------------------------------------
  // Control registers.
  // ------------------------------------------------------------------
  logic [6:0] pwrPrim_ff;
  logic [7:0] pwrAxes_ff;
  logic       userQEn_ff;
  logic [3:0] qRstCnt_ff;

  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      softRst_ff <= 1'b0;
      pwrPrim_ff <= PWR_PRIM_RST;
      pwrAxes_ff <= PWR_AXES_RST;
      userQEn_ff <= USER_QEN_RST;
    end else if (softRst_ff) begin
      softRst_ff <= 1'b0;
      pwrPrim_ff <= PWR_PRIM_RST;
      pwrAxes_ff <= PWR_AXES_RST;
      userQEn_ff <= USER_QEN_RST;
    end else if (hostWr) begin
      unique case (linkReq_ff.addr)
        ADDR_PWR_PRIM: begin
          softRst_ff <= linkReq_ff.data[PP_RESET_BIT];
          pwrPrim_ff <= linkReq_ff.data[6:0];
        end
        ADDR_PWR_AXES:  pwrAxes_ff <= linkReq_ff.data & PWR_AXES_MASK;
        ADDR_USER_CTRL: userQEn_ff <= linkReq_ff.data[UC_QEN_BIT];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      qRstCnt_ff <= 4'h0;
    end else if (hostWr && linkReq_ff.addr == ADDR_USER_CTRL &&
                 linkReq_ff.data[UC_QRST_BIT]) begin
      qRstCnt_ff <= 4'(QRST_CYC);
    end else if (qRstCnt_ff != 4'h0) begin
      qRstCnt_ff <= qRstCnt_ff - 4'h1;
    end
  end

  // ------------------------------------------------------------------
  // Power state decode.
  // ------------------------------------------------------------------
  logic       sleepBit;
  logic       cycleBit;
  logic       gyroStby;
  logic [2:0] clock_source_select;
  logic       cycleActive;

  assign sleepBit    = pwrPrim_ff[PP_SLEEP_BIT];
  assign cycleBit    = pwrPrim_ff[PP_CYCLE_BIT];
  assign gyroStby    = pwrPrim_ff[PP_GSTBY_BIT];
  assign clock_source_select      = pwrPrim_ff[PP_CLK_LSB +: 3];
  assign cycleActive = cycleBit && !sleepBit && !gyroStby;

  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      powerState <= '{sleepMode: 1'b1, timingGenRst: 1'b0,
                      clkUseOsc: 1'b1, default: '0};
    end else begin
      powerState.sleepMode    <= sleepBit;
      powerState.accelCycle   <= cycleActive;
      powerState.accelCapture <= cycleActive &&
                                 pwrAxes_ff[PA_ACC_LSB +: 3] != 3'b111;
      powerState.gyroSenseOff <= gyroStby;
      powerState.thermalOff   <= pwrPrim_ff[PP_TOFF_BIT];
      powerState.accelAxisOn  <= ~pwrAxes_ff[PA_ACC_LSB +: 3];
      powerState.gyroAxisOn   <= ~pwrAxes_ff[PA_GYR_LSB +: 3];
      powerState.timingGenRst <= clock_source_select == CLK_STOP;
      powerState.clkUseOsc    <= clock_source_select == CLK_OSC_A ||
                                 clock_source_select == CLK_OSC_B ||
                                 (clock_source_select != CLK_STOP && !pllSync_ff[1]);
      powerState.clkUsePll    <= clock_source_select != CLK_OSC_A &&
                                 clock_source_select != CLK_OSC_B &&
                                 clock_source_select != CLK_STOP && pllSync_ff[1];
    end
  end

  // ------------------------------------------------------------------
  // Sample sequencer.
  // ------------------------------------------------------------------
  function automatic logic byteEnabled(input int idx, input logic [4:0] src,
                                       input logic [7:0] axes,
                                       input logic [6:0] prim,
                                       input logic cyc);
    logic on;
    on = 1'b0;
    if (idx < 6) begin
      on = src[GRP_ACCEL] && !axes[PA_ACC_LSB + 2 - idx / 2];
    end else if (idx < 8) begin
      on = src[GRP_TEMP] && !prim[PP_TOFF_BIT] && !cyc;
    end else begin
      on = src[GRP_GYRO + (idx - 8) / 2] && !cyc &&
           !prim[PP_GSTBY_BIT] && !axes[PA_GYR_LSB + 2 - (idx - 8) / 2];
    end
    return on;
  endfunction

  logic [SENSOR_BYTES-1:0][7:0] snap_ff;
  logic [SENSOR_BYTES-1:0]      snapEn_ff;
  logic [3:0]                   seqIdx_ff;
  logic                         seqPush;
  logic [7:0]                   seqByte;
  logic                         startSeq;

  assign startSeq = sampleTick && seqState_ff == SEQ_IDLE && userQEn_ff &&
                    !sleepBit && !softRst_ff && qRstCnt_ff == 4'h0 &&
                    (!cycleActive || pwrAxes_ff[PA_LP_BIT]);

  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      seqState_ff <= SEQ_IDLE;
      seqIdx_ff   <= 4'h0;
      snap_ff     <= '0;
      snapEn_ff   <= '0;
    end else if (softRst_ff) begin
      seqState_ff <= SEQ_IDLE;
    end else begin
      unique case (seqState_ff)
        SEQ_IDLE: begin
          if (startSeq) begin
            seqState_ff <= SEQ_WALK;
            seqIdx_ff   <= 4'h0;
            snap_ff     <= sensorBytes;
            for (int i = 0; i < SENSOR_BYTES; i++) begin
              snapEn_ff[i] <= byteEnabled(i, queueSourceEn, pwrAxes_ff,
                                          pwrPrim_ff, cycleActive);
            end
          end
        end
        SEQ_WALK: begin
          seqIdx_ff <= seqIdx_ff + 4'h1;
          if (seqIdx_ff == 4'(SENSOR_BYTES - 1)) begin
            seqState_ff <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  assign seqPush = seqState_ff == SEQ_WALK && snapEn_ff[seqIdx_ff];
  assign seqByte = (snap_ff[seqIdx_ff] == EMPTY_MARK) ? SAMPLE_SUBST
                   : snap_ff[seqIdx_ff];

  // ------------------------------------------------------------------
  // Queue storage.
  // ------------------------------------------------------------------
  logic [7:0]    qMem [QDEPTH];
  logic [PW-1:0] wrPtr_ff;
  logic [PW-1:0] rdPtr_ff;
  logic [CW-1:0] count_ff;
  logic          qClear;
  logic          hostPush;
  logic          push;
  logic          pop;
  logic          full;
  logic [7:0]    pushByte;

  assign qClear   = softRst_ff || qRstCnt_ff != 4'h0;
  assign full     = count_ff == CW'(QDEPTH);
  assign hostPush = hostWr && linkReq_ff.addr == ADDR_DATA_PORT &&
                    userQEn_ff;
  assign push     = seqPush || hostPush;
  assign pushByte = seqPush ? seqByte : linkReq_ff.data;
  assign pop      = hostRd && linkReq_ff.addr == ADDR_DATA_PORT &&
                    userQEn_ff && count_ff != '0;

  always_ff @(posedge clk_sys) begin
    if (push && !(full && queueStopOnFull)) begin
      qMem[wrPtr_ff] <= pushByte;
    end
  end

  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      wrPtr_ff            <= '0;
      rdPtr_ff            <= '0;
      count_ff            <= '0;
      queue_overflow_flag <= 1'b0;
    end else if (qClear) begin
      wrPtr_ff            <= '0;
      rdPtr_ff            <= '0;
      count_ff            <= '0;
      queue_overflow_flag <= 1'b0;
    end else begin
      queue_overflow_flag <= push && full;
      if (push && full) begin
        if (!queueStopOnFull) begin
          wrPtr_ff <= wrPtr_ff + PW'(1);
          rdPtr_ff <= rdPtr_ff + PW'(1);
        end
      end else if (push) begin
        wrPtr_ff <= wrPtr_ff + PW'(1);
        count_ff <= count_ff + CW'(1);
      end else if (pop) begin
        rdPtr_ff <= rdPtr_ff + PW'(1);
        count_ff <= count_ff - CW'(1);
      end
    end
  end

  // ------------------------------------------------------------------
  // Read answers and count latch.
  // ------------------------------------------------------------------
  logic [LEVEL_W-1:0] lvlLatch_ff;
  logic [7:0]         rdValue;
  logic [LEVEL_W-1:0] liveLevel;

  assign liveLevel = LEVEL_W'(count_ff);

  always_comb begin
    rdValue = 8'h00;
    unique case (linkReq_ff.addr)
      ADDR_PWR_PRIM:  rdValue = {softRst_ff, pwrPrim_ff};
      ADDR_PWR_AXES:  rdValue = pwrAxes_ff;
      ADDR_USER_CTRL: rdValue = {1'b0, userQEn_ff, 3'b000,
                                 qRstCnt_ff != 4'h0, 2'b00};
      ADDR_LVL_HIGH:  rdValue = {3'b000,
                                 liveLevel[LEVEL_W-1:LVL_HIGH_LSB]};
      ADDR_LVL_LOW:   rdValue = lvlLatch_ff[7:0];
      ADDR_DATA_PORT: rdValue = pop ? qMem[rdPtr_ff] : EMPTY_MARK;
      default:        rdValue = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      lvlLatch_ff  <= '0;
      sysRdData_ff <= 8'h00;
      ackTgl_ff    <= 1'b0;
    end else if (serve) begin
      ackTgl_ff <= reqSync_ff[1];
      if (hostRd) begin
        sysRdData_ff <= rdValue;
      end
      if (hostRd && linkReq_ff.addr == ADDR_LVL_HIGH) begin
        lvlLatch_ff <= liveLevel;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------
  a_soft_reset_clear: assert property (@(posedge clk_sys)
    disable iff (!sysRst_n) softRst_ff |=> !softRst_ff &&
      pwrPrim_ff == PWR_PRIM_RST && count_ff == '0)
    else $error("soft reset did not restore defaults");

  a_cycle_capture: assert property (@(posedge clk_sys)
    disable iff (!sysRst_n)
    (cycleActive && pwrAxes_ff[PA_ACC_LSB +: 3] == 3'b111) |=>
      !powerState.accelCapture)
    else $error("capture enabled with all accel axes off");

  a_clock_stop: assert property (@(posedge clk_sys)
    disable iff (!sysRst_n || softRst_ff)
    (clock_source_select == CLK_STOP) [*2] |-> powerState.timingGenRst &&
      !powerState.clkUseOsc && !powerState.clkUsePll)
    else $error("stop code did not hold timing reset");

  a_queue_reset_len: assert property (@(posedge clk_sys)
    disable iff (!sysRst_n)
    $rose(qRstCnt_ff != 4'h0) |-> ##1 qRstCnt_ff == 4'h0)
    else $error("queue reset held too long");

  a_overflow_flag: assert property (@(posedge clk_sys)
    disable iff (!sysRst_n || qClear) push && full |=> queue_overflow_flag)
    else $error("overflow not flagged");

  a_stop_full_keep: assert property (@(posedge clk_sys)
    disable iff (!sysRst_n || qClear)
    push && full && queueStopOnFull |=> $stable(wrPtr_ff) &&
      $stable(rdPtr_ff))
    else $error("stop-on-full mode still wrote");

  a_empty_mark: assert property (@(posedge clk_sys)
    disable iff (!sysRst_n)
    hostRd && linkReq_ff.addr == ADDR_DATA_PORT && count_ff == '0 |=>
      sysRdData_ff == EMPTY_MARK)
    else $error("empty queue read not 0xFF");

  a_no_ff_sample: assert property (@(posedge clk_sys)
    disable iff (!sysRst_n) seqPush |-> seqByte != EMPTY_MARK)
    else $error("sample byte 0xFF pushed");

  a_walk_length: assert property (@(posedge clk_sys)
    disable iff (!sysRst_n || softRst_ff)
    startSeq |=> seqState_ff == SEQ_WALK [*8] ##6
      seqState_ff == SEQ_WALK ##1 seqState_ff == SEQ_IDLE)
    else $error("sample walk length wrong");

  a_link_answer: assert property (@(posedge linkClk)
    disable iff (!linkRst_n) linkBusy && ackSync_ff[1] == reqTgl_ff |=>
      !linkBusy)
    else $error("link answer did not end busy");

  c_overflow: cover property (@(posedge clk_sys) queue_overflow_flag);
  c_empty_read: cover property (@(posedge clk_sys)
    hostRd && linkReq_ff.addr == ADDR_DATA_PORT && count_ff == '0);
  c_level_latch: cover property (@(posedge clk_sys)
    hostRd && linkReq_ff.addr == ADDR_LVL_HIGH && count_ff != '0);

endmodule // pcq_power_queue

// file: shared/pcq_pkg.sv
// Constants and types of the power and sample queue control block.
package pcq_pkg;

  // ------------------------------------------------------------------
  // Register offsets.
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_USER_CTRL = 8'h6A;
  localparam logic [7:0] ADDR_PWR_PRIM  = 8'h6B;
  localparam logic [7:0] ADDR_PWR_AXES  = 8'h6C;
  localparam logic [7:0] ADDR_LVL_HIGH  = 8'h72;
  localparam logic [7:0] ADDR_LVL_LOW   = 8'h73;
  localparam logic [7:0] ADDR_DATA_PORT = 8'h74;

  // ------------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------------
  localparam int PP_RESET_BIT = 7;
  localparam int PP_SLEEP_BIT = 6;
  localparam int PP_CYCLE_BIT = 5;
  localparam int PP_GSTBY_BIT = 4;
  localparam int PP_TOFF_BIT  = 3;
  localparam int PP_CLK_LSB   = 0;
  localparam int PA_LP_BIT    = 7;
  localparam int PA_ACC_LSB   = 3;
  localparam int PA_GYR_LSB   = 0;
  localparam int UC_QEN_BIT   = 6;
  localparam int UC_QRST_BIT  = 2;
  localparam int LVL_HIGH_LSB = 8;

  // ------------------------------------------------------------------
  // Reset values, masks and markers.
  // ------------------------------------------------------------------
  localparam logic [6:0] PWR_PRIM_RST  = 7'h40;
  localparam logic [7:0] PWR_AXES_RST  = 8'h00;
  localparam logic [7:0] PWR_AXES_MASK = 8'hBF;
  localparam logic       USER_QEN_RST  = 1'b0;
  localparam logic [7:0] EMPTY_MARK    = 8'hFF;
  localparam logic [7:0] SAMPLE_SUBST  = 8'hFE;

  // ------------------------------------------------------------------
  // Clock source codes and sensor byte layout.
  // ------------------------------------------------------------------
  localparam logic [2:0] CLK_OSC_A = 3'h0;
  localparam logic [2:0] CLK_OSC_B = 3'h6;
  localparam logic [2:0] CLK_STOP  = 3'h7;
  localparam int SENSOR_FIRST_REG = 59;
  localparam int SENSOR_LAST_REG  = 72;
  localparam int SENSOR_BYTES     = SENSOR_LAST_REG - SENSOR_FIRST_REG + 1;
  localparam int GRP_ACCEL = 0;
  localparam int GRP_TEMP  = 1;
  localparam int GRP_GYRO  = 2;
  localparam int QDEPTH_DEF = 512;
  localparam int LEVEL_W    = 13;

  // ------------------------------------------------------------------
  // Timing.
  // ------------------------------------------------------------------
  localparam int SYS_CLK_MHZ  = 20;
  localparam int QRST_HOLD_NS = 50;
  localparam int QRST_CYC_RAW = (QRST_HOLD_NS * SYS_CLK_MHZ) / 1000;
  localparam int QRST_CYC     = (QRST_CYC_RAW < 1) ? 1 : QRST_CYC_RAW;

  // ------------------------------------------------------------------
  // Types.
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       sleepMode;
    logic       accelCycle;
    logic       accelCapture;
    logic       gyroSenseOff;
    logic       thermalOff;
    logic [2:0] accelAxisOn;
    logic [2:0] gyroAxisOn;
    logic       clkUseOsc;
    logic       clkUsePll;
    logic       timingGenRst;
  } pcq_pwr_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       write;
  } pcq_req_t;

  typedef enum logic {SEQ_IDLE, SEQ_WALK} pcq_seq_t;

endpackage

// file: tb/pcq_host_model.sv
// Host model that drives the register link of the block.
`timescale 1ns/100ps
module pcq_host_model (
  input  wire logic       linkClk,
  input  wire logic       linkBusy,
  input  wire logic       linkRdValid,
  input  wire logic [7:0] linkRdData,
  output logic            linkWrite,
  output logic            linkRead,
  output logic [7:0]      linkAddr,
  output logic [7:0]      linkWrData
);
  initial {linkWrite, linkRead, linkAddr, linkWrData} = '0;
  // One request held for one cycle, then a bounded wait for the answer.
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q, output logic ok);
    int n;
    @(negedge linkClk);
    {linkWrite, linkRead, linkAddr, linkWrData} = {w, !w, a, d};
    @(negedge linkClk);
    {linkWrite, linkRead, linkAddr, linkWrData} = {2'b00, ~a, ~d};
    for (n = 0; n < 400 && linkBusy !== 1'b0; n++) @(negedge linkClk);
    q = linkRdData;
    ok = (linkBusy === 1'b0) && (linkRdValid === !w);
  endtask
endmodule // pcq_host_model

// file: tb/testbench.sv
// Self-checking bench of the power and sample queue control block.
`timescale 1ns/100ps
module testbench;
  import pcq_pkg::*;
  localparam int QD = 16;
  logic       clk_sys = 0, rst_n = 0, linkClk = 0, sampleTick = 0;
  logic       queueStopOnFull = 0, pllReady = 0, ok, ovf;
  logic       linkWrite, linkRead, linkBusy, linkRdValid;
  logic [7:0] linkAddr, linkWrData, linkRdData, q;
  logic [4:0] queueSourceEn = 5'h1F;
  logic [2:0] ex;
  logic [SENSOR_BYTES-1:0][7:0] sensorBytes;
  pcq_pwr_t   powerState;
  int         fails = 0, comparisons = 0, ovfCnt = 0;
  always #25 clk_sys = ~clk_sys;
  always #3 linkClk = ~linkClk;
  always @(negedge clk_sys) if (ovf === 1'b1) ovfCnt <= ovfCnt + 1;
  pcq_power_queue #(.QDEPTH(QD)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .linkClk(linkClk), .linkWrite(linkWrite), .linkRead(linkRead),
    .linkAddr(linkAddr), .linkWrData(linkWrData), .linkBusy(linkBusy),
    .linkRdValid(linkRdValid), .linkRdData(linkRdData),
    .sampleTick(sampleTick), .sensorBytes(sensorBytes),
    .queueSourceEn(queueSourceEn), .queueStopOnFull(queueStopOnFull),
    .pllReady(pllReady), .powerState(powerState),
    .queue_overflow_flag(ovf));
  pcq_host_model host (.linkClk(linkClk), .linkBusy(linkBusy),
    .linkRdValid(linkRdValid), .linkRdData(linkRdData),
    .linkWrite(linkWrite), .linkRead(linkRead),
    .linkAddr(linkAddr), .linkWrData(linkWrData));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d);
    host.xfer(w, a, d, q, ok);
    if (ok !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    acc(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic tick();
    @(negedge clk_sys) sampleTick = 1;
    @(negedge clk_sys) sampleTick = 0;
    repeat (20) @(negedge clk_sys);
  endtask
  initial begin
    for (int i = 0; i < SENSOR_BYTES; i++) sensorBytes[i] = 8'h10 + 8'(i);
    sensorBytes[5] = 8'hFF;
    repeat (2) @(negedge clk_sys);
    rst_n = 1;
    repeat (4) @(negedge clk_sys);
    rd(ADDR_PWR_PRIM, 8'h40);
    rd(ADDR_PWR_AXES, 8'h00);
    chk({7'h0, powerState.sleepMode}, 8'h01);
    rd(8'h10, 8'h00);
    for (int c = 0; c < 8; c++) begin
      pllReady = (c != 2 && c != 4);
      wr(ADDR_PWR_PRIM, 8'(c));
      ex = (c == 7) ? 3'b001 : (c == 0 || c == 6 || !c[0]) ? 3'b100 : 3'b010;
      chk({5'h0, powerState.clkUseOsc, powerState.clkUsePll,
           powerState.timingGenRst}, {5'h0, ex});
    end
    wr(ADDR_PWR_PRIM, 8'h28);
    chk({4'h0, powerState.accelCycle, powerState.accelCapture,
         powerState.gyroSenseOff, powerState.thermalOff}, 8'h0D);
    wr(ADDR_PWR_AXES, 8'h38);
    chk({7'h0, powerState.accelCapture}, 8'h00);
    wr(ADDR_PWR_PRIM, 8'h10);
    chk({5'h0, powerState.accelCycle, powerState.gyroSenseOff,
         powerState.thermalOff}, 8'h02);
    wr(ADDR_PWR_AXES, 8'hED);
    rd(ADDR_PWR_AXES, 8'hAD);
    chk({2'h0, powerState.accelAxisOn, powerState.gyroAxisOn},
        8'h12);
    wr(ADDR_PWR_PRIM, 8'h80);
    rd(ADDR_PWR_PRIM, 8'h40);
    rd(ADDR_PWR_AXES, 8'h00);
    wr(ADDR_USER_CTRL, 8'h40);
    wr(ADDR_PWR_PRIM, 8'h01);
    tick();
    rd(ADDR_LVL_HIGH, 8'h00);
    rd(ADDR_LVL_LOW, 8'h0E);
    for (int i = 0; i < 14; i++)
      rd(ADDR_DATA_PORT, (i == 5) ? 8'hFE : 8'h10 + 8'(i));
    rd(ADDR_DATA_PORT, 8'hFF);
    rd(ADDR_DATA_PORT, 8'hFF);
    rd(ADDR_LVL_LOW, 8'h0E);
    rd(ADDR_LVL_HIGH, 8'h00);
    rd(ADDR_LVL_LOW, 8'h00);
    queueSourceEn = 5'h02;
    tick();
    rd(ADDR_DATA_PORT, 8'h16);
    rd(ADDR_DATA_PORT, 8'h17);
    rd(ADDR_DATA_PORT, 8'hFF);
    queueSourceEn = 5'h1F;
    wr(ADDR_DATA_PORT, 8'h5A);
    rd(ADDR_DATA_PORT, 8'h5A);
    tick();
    tick();
    chk(8'(ovfCnt), 8'h0C);
    rd(ADDR_DATA_PORT, 8'h1C);
    wr(ADDR_USER_CTRL, 8'h44);
    rd(ADDR_LVL_HIGH, 8'h00);
    rd(ADDR_LVL_LOW, 8'h00);
    queueStopOnFull = 1;
    tick();
    tick();
    chk(8'(ovfCnt), 8'h18);
    rd(ADDR_LVL_HIGH, 8'h00);
    rd(ADDR_LVL_LOW, 8'h10);
    rd(ADDR_DATA_PORT, 8'h10);
    wr(ADDR_USER_CTRL, 8'h00);
    rd(ADDR_DATA_PORT, 8'hFF);
    rd(ADDR_LVL_HIGH, 8'h00);
    rd(ADDR_LVL_LOW, 8'h0F);
    wr(ADDR_USER_CTRL, 8'h44);
    wr(ADDR_PWR_PRIM, 8'h21);
    tick();
    rd(ADDR_LVL_HIGH, 8'h00);
    rd(ADDR_LVL_LOW, 8'h00);
    wr(ADDR_PWR_AXES, 8'h80);
    tick();
    rd(ADDR_LVL_HIGH, 8'h00);
    rd(ADDR_LVL_LOW, 8'h06);
    wr(ADDR_PWR_AXES, 8'hB8);
    tick();
    rd(ADDR_LVL_HIGH, 8'h00);
    rd(ADDR_LVL_LOW, 8'h06);
    wr(ADDR_PWR_PRIM, 8'h41);
    wr(ADDR_PWR_AXES, 8'h00);
    tick();
    rd(ADDR_LVL_HIGH, 8'h00);
    rd(ADDR_LVL_LOW, 8'h06);
    rd(ADDR_DATA_PORT, 8'h10);
    tally_and_finish();
  end
endmodule // testbench
